// [design/clock_fanout_gating.sv]
module clock_fanout_gating #(
    parameter int STARTUP_CYC = clock_fanout_pkg::STARTUP_CYC,
    parameter int PD_EXIT_CYC = clock_fanout_pkg::PD_EXIT_CYC,
    parameter logic [3:0] VENDOR_ID = 4'h5, // arbitrary value
    parameter logic [3:0] REV_ID = 4'h2, // arbitrary value
    parameter logic [7:0] DEVICE_ID = 8'h3C // arbitrary value
) (
    // clocks and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic ref_clock_in,
    // power-good and address straps
    input wire logic power_good_powerdown_n,
    input wire logic [1:0] bus_addr_strap_hi,
    input wire logic [1:0] bus_addr_strap_lo,
    // output enable pins
    input wire logic [clock_fanout_pkg::NUM_OE_PINS-1:0] output_enable_pin_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [clock_fanout_pkg::PADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // outputs
    output logic [clock_fanout_pkg::NUM_PAIRS-1:0] clock_output_pair_p,
    output logic [clock_fanout_pkg::NUM_PAIRS-1:0] clock_output_pair_n,
    output logic [7:0] bus_write_addr
);
    import clock_fanout_pkg::*;

    generate
        if (STARTUP_CYC < 1 || STARTUP_CYC > STARTUP_MAX_CYC) begin : g_bad_start
            $error("STARTUP_CYC out of range");
        end
        if (PD_EXIT_CYC < 1 || PD_EXIT_CYC > PD_EXIT_MAX_CYC) begin : g_bad_exit
            $error("PD_EXIT_CYC out of range");
        end
        if (STARTUP_MAX_CYC >= 2 ** CNT_W) begin : g_bad_cnt
            $error("CNT_W too narrow");
        end
    endgenerate

    gate_ctl_if ctl_if ();

    logic pg_s1_r;
    logic pg_s2_r;
    logic [1:0] hi_s1_r;
    logic [1:0] hi_s2_r;
    logic [1:0] lo_s1_r;
    logic [1:0] lo_s2_r;
    logic [NUM_OE_PINS-1:0] rb_s1_r;
    logic [NUM_OE_PINS-1:0] rb_s2_r;
    logic [7:0] addr_w;
    pwr_state_t state_r;
    logic [CNT_W-1:0] wait_cnt_r;
    logic started_r;
    logic outputs_on_r;
    logic from_pd_r;
    logic [CNT_W-1:0] off_cnt_r;
    logic [NUM_PAIRS-1:0] en_r;
    logic [7:0] cfg_a_r;
    logic [7:0] cfg_b_r;
    logic [CFG_C_W-1:0] cfg_c_r;
    logic [2:0] amp_r;
    logic [4:0] bcnt_r;
    logic [4:0] idx_w;
    logic mapped_w;
    logic wr_w;
    logic [7:0] rbyte_w;
    logic [31:0] prdata_r;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pg_s1_r <= 1'b0;
            pg_s2_r <= 1'b0;
            hi_s1_r <= 2'h0;
            hi_s2_r <= 2'h0;
            lo_s1_r <= 2'h0;
            lo_s2_r <= 2'h0;
            rb_s1_r <= '1;
            rb_s2_r <= '1;
        end else begin
            pg_s1_r <= power_good_powerdown_n;
            pg_s2_r <= pg_s1_r;
            hi_s1_r <= bus_addr_strap_hi;
            hi_s2_r <= hi_s1_r;
            lo_s1_r <= bus_addr_strap_lo;
            lo_s2_r <= lo_s1_r;
            rb_s1_r <= output_enable_pin_n;
            rb_s2_r <= rb_s1_r;
        end
    end

    strap_addr_decode u_decode (
        .strap_hi(hi_s2_r),
        .strap_lo(lo_s2_r),
        .write_addr(addr_w)
    );

    // ----------------------------------------
    // power sequencing
    // ----------------------------------------
    // straps are caught once; later changes on those pins are ignored
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_write_addr <= ADDR_LOW_LOW;
            started_r <= 1'b0;
        end else if (state_r == ST_IDLE && pg_s2_r) begin
            bus_write_addr <= addr_w;
            started_r <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            wait_cnt_r <= '0;
            outputs_on_r <= 1'b0;
            from_pd_r <= 1'b0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (pg_s2_r) begin
                        state_r <= ST_WAIT;
                        wait_cnt_r <= CNT_W'(STARTUP_CYC - 1);
                        from_pd_r <= 1'b0;
                    end
                end
                ST_WAIT: begin
                    if (!pg_s2_r) begin
                        state_r <= ST_DOWN;
                    end else if (wait_cnt_r == '0) begin
                        state_r <= ST_RUN;
                        outputs_on_r <= 1'b1;
                    end else begin
                        wait_cnt_r <= wait_cnt_r - 1'b1;
                    end
                end
                ST_RUN: begin
                    if (!pg_s2_r) begin
                        state_r <= ST_DOWN;
                        outputs_on_r <= 1'b0;
                    end
                end
                ST_DOWN: begin
                    if (pg_s2_r) begin
                        state_r <= ST_WAIT;
                        wait_cnt_r <= CNT_W'(PD_EXIT_CYC - 1);
                        from_pd_r <= 1'b1;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                    outputs_on_r <= 1'b0;
                end
            endcase
        end
    end

    // helper for the delay bounds below
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            off_cnt_r <= '0;
        end else if (state_r == ST_WAIT) begin
            off_cnt_r <= off_cnt_r + 1'b1;
        end else begin
            off_cnt_r <= '0;
        end
    end

    // ----------------------------------------
    // apb decode
    // ----------------------------------------
    assign idx_w = paddr[6:2];
    assign mapped_w = (paddr[PADDR_W-1] == 1'b0) && (paddr[1:0] == 2'b00)
        && (idx_w <= IDX_CFG_C || idx_w == IDX_STATUS);
    assign wr_w = psel && penable && pwrite && pstrb[0] && mapped_w;
    // zero wait states; unmapped or misaligned access answers with an error
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped_w;

    // ----------------------------------------
    // writable registers
    // ----------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            en_r <= {RST_OE_HI[OE_HI_LSB +: 4], RST_OE_MID, RST_OE_LO};
        end else if (wr_w) begin
            case (idx_w)
                IDX_OE_HI: en_r[19:16] <= pwdata[OE_HI_LSB +: 4];
                IDX_OE_LO: en_r[7:0] <= pwdata[7:0];
                IDX_OE_MID: en_r[15:8] <= pwdata[7:0];
                default: en_r <= en_r;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_a_r <= RST_CFG_A;
            cfg_b_r <= RST_CFG_B;
            cfg_c_r <= RST_CFG_C;
            amp_r <= RST_AMP;
        end else if (wr_w) begin
            case (idx_w)
                IDX_CFG_A: cfg_a_r <= pwdata[7:0];
                IDX_CFG_B: cfg_b_r <= pwdata[7:0];
                IDX_CFG_C: begin
                    cfg_c_r <= pwdata[CFG_C_LSB +: CFG_C_W];
                    amp_r <= pwdata[2:0];
                end
                default: cfg_a_r <= cfg_a_r;
            endcase
        end
    end

    // read length for the management bus block read
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            bcnt_r <= RST_BCNT;
        end else if (wr_w && idx_w == IDX_BCNT) begin
            bcnt_r <= pwdata[4:0];
        end
    end

    // ----------------------------------------
    // read path
    // ----------------------------------------
    always_comb begin
        rbyte_w = 8'h00;
        case (idx_w)
            IDX_OE_HI: rbyte_w = {1'b0, en_r[19:16], 3'b000};
            IDX_OE_LO: rbyte_w = en_r[7:0];
            IDX_OE_MID: rbyte_w = en_r[15:8];
            IDX_PIN_RB: rbyte_w = rb_s2_r;
            IDX_RSVD: rbyte_w = 8'h00;
            IDX_REV_VEN: rbyte_w = {REV_ID, VENDOR_ID};
            IDX_DEV: rbyte_w = DEVICE_ID;
            IDX_BCNT: rbyte_w = {3'b000, bcnt_r};
            IDX_CFG_A: rbyte_w = cfg_a_r;
            IDX_CFG_B: rbyte_w = cfg_b_r;
            IDX_CFG_C: rbyte_w = {cfg_c_r, 1'b0, amp_r};
            IDX_STATUS: rbyte_w = bus_write_addr;
            default: rbyte_w = 8'h00;
        endcase
    end

    // read data is captured in the setup cycle so prdata comes from a flop
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata_r <= 32'h0000_0000;
        end else if (psel && !penable) begin
            prdata_r <= {24'h00_0000, rbyte_w};
            if (mapped_w && idx_w == IDX_STATUS) begin
                prdata_r[ST_STARTED_BIT] <= started_r;
                prdata_r[ST_ON_BIT] <= outputs_on_r;
                prdata_r[ST_PG_BIT] <= pg_s2_r;
            end
            if (!mapped_w) begin
                prdata_r <= 32'h0000_0000;
            end
        end
    end
    assign prdata = prdata_r;

    // ----------------------------------------
    // link side
    // ----------------------------------------
    assign ctl_if.out_en = en_r;
    assign ctl_if.cfg_a = cfg_a_r;
    assign ctl_if.cfg_b = cfg_b_r;
    assign ctl_if.cfg_c = cfg_c_r;
    assign ctl_if.outputs_on = outputs_on_r;

    ref_output_gate u_gate (
        .ref_clock_in(ref_clock_in),
        .rst_n(rst_n),
        .output_enable_pin_n(output_enable_pin_n),
        .ctl(ctl_if.gate),
        .clock_output_pair_p(clock_output_pair_p),
        .clock_output_pair_n(clock_output_pair_n)
    );

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_pd_parks_all: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !pg_s2_r |=> !outputs_on_r) else $error("outputs stay on while power-good is low");
    a_on_needs_start: assert property (@(posedge sys_clk) disable iff (!rst_n)
        outputs_on_r |-> started_r && $past(pg_s2_r)) else $error("outputs on before start");
    a_start_bound: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state_r == ST_WAIT && !from_pd_r |-> off_cnt_r < CNT_W'(STARTUP_CYC))
        else $error("start-up wait too long");
    a_pd_exit_bound: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state_r == ST_WAIT && from_pd_r |-> off_cnt_r < CNT_W'(PD_EXIT_CYC))
        else $error("power-down exit wait too long");
    a_addr_decoded: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(started_r) |-> bus_write_addr == $past(addr_w))
        else $error("bus address not taken from straps");
    a_addr_held: assert property (@(posedge sys_clk) disable iff (!rst_n)
        started_r && $past(started_r) |-> $stable(bus_write_addr))
        else $error("bus address changed after start");
    a_enable_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
        psel && penable && pwrite && pstrb[0] && paddr == {1'b0, IDX_OE_LO, 2'b00}
        |=> en_r[7:0] == $past(pwdata[7:0])) else $error("enable bits not written");
endmodule

// [design/clock_fanout_pkg.sv]
package clock_fanout_pkg;

    // ----------------------------------------
    // sizes
    // ----------------------------------------
    localparam int NUM_PAIRS = 20;
    localparam int NUM_OE_PINS = 8;
    localparam int CFG_C_W = 4;
    localparam int PADDR_W = 8;
    localparam int CNT_W = 20;

    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam real SYS_CLK_PERIOD_NS = 4.0;
    localparam real T_STAB_TYP_MS = 1.0;
    localparam real T_STAB_MAX_MS = 1.8;
    localparam real T_DRVPD_TYP_US = 76.0;
    localparam real T_DRVPD_MAX_US = 300.0;
    localparam int STARTUP_CYC = int'($ceil(T_STAB_TYP_MS * 1.0e6 / SYS_CLK_PERIOD_NS));
    localparam int STARTUP_MAX_CYC = int'($floor(T_STAB_MAX_MS * 1.0e6 / SYS_CLK_PERIOD_NS));
    localparam int PD_EXIT_CYC = int'($ceil(T_DRVPD_TYP_US * 1.0e3 / SYS_CLK_PERIOD_NS));
    localparam int PD_EXIT_MAX_CYC = int'($floor(T_DRVPD_MAX_US * 1.0e3 / SYS_CLK_PERIOD_NS));
    localparam int OE_LAT_MIN_CLK = 4;
    localparam int OE_LAT_MAX_CLK = 10;

    // ----------------------------------------
    // register indices (byte address is index times four)
    // ----------------------------------------
    localparam logic [4:0] IDX_OE_HI = 5'h00;
    localparam logic [4:0] IDX_OE_LO = 5'h01;
    localparam logic [4:0] IDX_OE_MID = 5'h02;
    localparam logic [4:0] IDX_PIN_RB = 5'h03;
    localparam logic [4:0] IDX_RSVD = 5'h04;
    localparam logic [4:0] IDX_REV_VEN = 5'h05;
    localparam logic [4:0] IDX_DEV = 5'h06;
    localparam logic [4:0] IDX_BCNT = 5'h07;
    localparam logic [4:0] IDX_CFG_A = 5'h08;
    localparam logic [4:0] IDX_CFG_B = 5'h09;
    localparam logic [4:0] IDX_CFG_C = 5'h0A;
    localparam logic [4:0] IDX_STATUS = 5'h10;

    // ----------------------------------------
    // reset values and fields
    // ----------------------------------------
    localparam logic [7:0] RST_OE_HI = 8'h78;
    localparam logic [7:0] RST_OE_LO = 8'hFF;
    localparam logic [7:0] RST_OE_MID = 8'hFF;
    localparam logic [4:0] RST_BCNT = 5'h08;
    localparam logic [7:0] RST_CFG_A = 8'hFF;
    localparam logic [7:0] RST_CFG_B = 8'h00;
    localparam logic [3:0] RST_CFG_C = 4'h0;
    localparam logic [2:0] RST_AMP = 3'h5;
    localparam int OE_HI_LSB = 3;
    localparam int CFG_C_LSB = 4;
    localparam int ST_STARTED_BIT = 8;
    localparam int ST_ON_BIT = 9;
    localparam int ST_PG_BIT = 10;

    // ----------------------------------------
    // strap decode
    // ----------------------------------------
    localparam logic [1:0] TRI_LOW = 2'h0;
    localparam logic [1:0] TRI_MID = 2'h1;
    localparam logic [7:0] ADDR_LOW_LOW = 8'hD8;
    localparam logic [7:0] ADDR_LOW_MID = 8'hDA;
    localparam logic [7:0] ADDR_LOW_HIGH = 8'hDE;
    localparam logic [7:0] ADDR_MID_LOW = 8'hC2;
    localparam logic [7:0] ADDR_MID_MID = 8'hC4;
    localparam logic [7:0] ADDR_MID_HIGH = 8'hC6;
    localparam logic [7:0] ADDR_HIGH_LOW = 8'hCA;
    localparam logic [7:0] ADDR_HIGH_MID = 8'hCC;
    localparam logic [7:0] ADDR_HIGH_HIGH = 8'hCE;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_RUN = 2'b10,
        ST_DOWN = 2'b11
    } pwr_state_t;

endpackage

// [design/gate_ctl_if.sv]
interface gate_ctl_if;
    import clock_fanout_pkg::*;
    logic [NUM_PAIRS-1:0] out_en;
    logic [7:0] cfg_a;
    logic [7:0] cfg_b;
    logic [CFG_C_W-1:0] cfg_c;
    logic outputs_on;
    modport ctl (output out_en, output cfg_a, output cfg_b, output cfg_c, output outputs_on);
    modport gate (input out_en, input cfg_a, input cfg_b, input cfg_c, input outputs_on);
endinterface

// [design/strap_addr_decode.sv]
module strap_addr_decode (
    // strap levels, already synchronised
    input wire logic [1:0] strap_hi,
    input wire logic [1:0] strap_lo,
    // decoded bus write address
    output logic [7:0] write_addr
);
    import clock_fanout_pkg::*;

    // a code of 3 is read as high
    always_comb begin
        write_addr = ADDR_HIGH_HIGH;
        case (strap_hi)
            TRI_LOW: begin
                case (strap_lo)
                    TRI_LOW: write_addr = ADDR_LOW_LOW;
                    TRI_MID: write_addr = ADDR_LOW_MID;
                    default: write_addr = ADDR_LOW_HIGH;
                endcase
            end
            TRI_MID: begin
                case (strap_lo)
                    TRI_LOW: write_addr = ADDR_MID_LOW;
                    TRI_MID: write_addr = ADDR_MID_MID;
                    default: write_addr = ADDR_MID_HIGH;
                endcase
            end
            default: begin
                case (strap_lo)
                    TRI_LOW: write_addr = ADDR_HIGH_LOW;
                    TRI_MID: write_addr = ADDR_HIGH_MID;
                    default: write_addr = ADDR_HIGH_HIGH;
                endcase
            end
        endcase
    end
endmodule

// [design/ref_output_gate.sv]
module ref_output_gate (
    // link clock and reset
    input wire logic ref_clock_in,
    input wire logic rst_n,
    // enable pins, raw
    input wire logic [clock_fanout_pkg::NUM_OE_PINS-1:0] output_enable_pin_n,
    // control from the register side
    gate_ctl_if.gate ctl,
    // output pairs
    output logic [clock_fanout_pkg::NUM_PAIRS-1:0] clock_output_pair_p,
    output logic [clock_fanout_pkg::NUM_PAIRS-1:0] clock_output_pair_n
);
    import clock_fanout_pkg::*;
    localparam int CTL_W = NUM_PAIRS + 16 + CFG_C_W + 1;

    logic [1:0] rrst_r;
    logic ref_rst_n;
    logic [CTL_W-1:0] ctl_s1_r;
    logic [CTL_W-1:0] ctl_s2_r;
    logic [NUM_OE_PINS-1:0] pin_s1_r;
    logic [NUM_OE_PINS-1:0] pin_s2_r;
    logic [NUM_PAIRS-1:0] en_s;
    logic [7:0] cfg_a_s;
    logic [7:0] cfg_b_s;
    logic [CFG_C_W-1:0] cfg_c_s;
    logic on_s;
    logic [NUM_PAIRS-1:0] park_w;
    logic [NUM_PAIRS-1:0] dec_r;
    logic [NUM_PAIRS-1:0] d1_r;
    logic [NUM_PAIRS-1:0] d2_r;
    logic [NUM_PAIRS-1:0] run_r;

    // ----------------------------------------
    // reset release and crossings
    // ----------------------------------------
    always_ff @(posedge ref_clock_in or negedge rst_n) begin
        if (!rst_n) begin
            rrst_r <= 2'b00;
        end else begin
            rrst_r <= {rrst_r[0], 1'b1};
        end
    end
    assign ref_rst_n = rrst_r[1];

    // each bit is an independent level, so a plain two-stage sync is enough
    always_ff @(posedge ref_clock_in or negedge ref_rst_n) begin
        if (!ref_rst_n) begin
            ctl_s1_r <= '0;
            ctl_s2_r <= '0;
            pin_s1_r <= '1;
            pin_s2_r <= '1;
        end else begin
            ctl_s1_r <= {ctl.outputs_on, ctl.cfg_c, ctl.cfg_b, ctl.cfg_a, ctl.out_en};
            ctl_s2_r <= ctl_s1_r;
            pin_s1_r <= output_enable_pin_n;
            pin_s2_r <= pin_s1_r;
        end
    end
    assign {on_s, cfg_c_s, cfg_b_s, cfg_a_s, en_s} = ctl_s2_r;

    // ----------------------------------------
    // pin steering per pair
    // ----------------------------------------
    genvar j;
    generate
        for (j = 0; j < NUM_PAIRS; j++) begin : g_pair
            if (j < 5) begin : g_b_lo
                assign park_w[j] = cfg_b_s[4-j] & pin_s2_r[4-j];
            end else if (j < 13) begin : g_a
                assign park_w[j] = cfg_a_s[j-5] & pin_s2_r[j-5];
            end else if (j < 16) begin : g_b_hi
                assign park_w[j] = cfg_b_s[20-j] & pin_s2_r[20-j];
            end else begin : g_c
                assign park_w[j] = cfg_c_s[19-j] & pin_s2_r[23-j];
            end
        end
    endgenerate

    // ----------------------------------------
    // decision pipeline and glitch-free gate
    // ----------------------------------------
    always_ff @(posedge ref_clock_in or negedge ref_rst_n) begin
        if (!ref_rst_n) begin
            dec_r <= '0;
            d1_r <= '0;
            d2_r <= '0;
        end else begin
            dec_r <= {NUM_PAIRS{on_s}} & en_s & ~park_w;
            d1_r <= dec_r;
            d2_r <= d1_r;
        end
    end

    // enable moves only while the clock is low, so no pulse is cut short
    always_ff @(negedge ref_clock_in or negedge ref_rst_n) begin
        if (!ref_rst_n) begin
            run_r <= '0;
        end else begin
            run_r <= d2_r;
        end
    end

    assign clock_output_pair_p = {NUM_PAIRS{ref_clock_in}} & run_r;
    assign clock_output_pair_n = {NUM_PAIRS{~ref_clock_in}} & run_r;

    a_run_follows_dec: assert property (@(posedge ref_clock_in) disable iff (!ref_rst_n)
        run_r == $past(dec_r, 2)) else $error("pair gate does not follow decision by 2 cycles");
    a_park_no_power: assert property (@(posedge ref_clock_in) disable iff (!ref_rst_n)
        !on_s |=> ##3 (run_r == '0 || $past(on_s, 3))) else $error("pair runs without power");
    a_table_enable: assert property (@(posedge ref_clock_in) disable iff (!ref_rst_n)
        on_s |=> ((dec_r & ~$past(en_s)) == '0) && (($past(en_s & ~park_w) & ~dec_r) == '0))
        else $error("pair decision does not match enable table");
endmodule

// [verification/apb_host_model.sv]
module apb_host_model (
    // clock
    input wire logic sys_clk,
    // apb master side
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    output logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------------------------------
    // one transfer, held until pready or for at most 50 cycles
    // ----------------------------------------
    initial begin
        {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    end
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge sys_clk);
        {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, d, 4'hF};
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1 && ++n < 50);
        rd = prdata;
        err = (n < 50) ? pslverr : 1'bx;
        {psel, penable} <= 2'b00;
    endtask
endmodule

// [verification/clock_fanout_output_gating_test.sv]
module clock_fanout_output_gating_test;
    timeunit 1ns;
    timeprecision 100ps;
    import clock_fanout_pkg::*;
    logic sys_clk = 0, rst_n = 0, rclk = 0, pg = 0, psel, penable, pwrite, pready, pslverr, err;
    logic [1:0] s_hi, s_lo;
    logic [7:0] oe_n = 8'hFF, paddr, wa, cfg;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic [19:0] cp, cn, en, old;
    int n_fail = 0, checks = 0, seed = 76, i;
    // ----------------------------------------
    // clocks, design, host
    // ----------------------------------------
    initial forever #2 sys_clk = ~sys_clk;
    initial begin
        #1.3;
        forever #16 rclk = ~rclk;
    end
    clock_fanout_gating #(.STARTUP_CYC(20), .PD_EXIT_CYC(10)) DUT (.sys_clk, .rst_n,
        .ref_clock_in(rclk), .power_good_powerdown_n(pg), .bus_addr_strap_hi(s_hi),
        .bus_addr_strap_lo(s_lo), .output_enable_pin_n(oe_n), .psel, .penable, .pwrite,
        .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .clock_output_pair_p(cp),
        .clock_output_pair_n(cn), .bus_write_addr(wa));
    apb_host_model HOST (.sys_clk, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr);
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // a host wait that runs out ends the run as a failure
    task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d);
        HOST.xfer(w, a, d, rd, err);
        if (err === 1'bx) begin
            n_fail++;
            report_and_stop;
        end
    endtask
    task automatic rd_chk(input logic [4:0] idx, input logic [31:0] exp);
        xf(1'b0, {1'b0, idx, 2'b00}, 32'h0);
        chk("register", rd, exp);
    endtask
    task automatic wr(input logic [4:0] idx, input logic [31:0] d);
        xf(1'b1, {1'b0, idx, 2'b00}, d);
    endtask
    function automatic logic [7:0] exp_addr(input logic [1:0] h, input logic [1:0] l);
        logic [7:0] t[9] = '{8'hD8, 8'hDA, 8'hDE, 8'hC2, 8'hC4, 8'hC6, 8'hCA, 8'hCC, 8'hCE};
        return t[(h > 2 ? 2 : h) * 3 + (l > 2 ? 2 : l)];
    endfunction
    // only cfg a routes pins here; cfg b and c stay 0
    function automatic logic [19:0] mask(input logic [19:0] e, input logic [7:0] p,
                                         input logic [7:0] c);
        mask = e;
        for (int k = 5; k < 13; k++) mask[k] = e[k] & ~(c[k-5] & p[k-5]);
    endfunction
    // true side seen with ref high, complement with ref low
    task automatic pairs(input logic [19:0] exp);
        @(posedge rclk);
        #2 chk("pair true", 32'(cp), 32'(exp));
        @(negedge rclk);
        #2 chk("pair comp", 32'(cn), 32'(exp));
    endtask
    task automatic wait_on;
        i = 0;
        do xf(1'b0, 8'h40, 32'h0); while (rd[9] !== 1'b1 && ++i < 100);
        if (i == 100) begin
            n_fail++;
            report_and_stop;
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        s_hi = 2'($unsigned($random(seed)) % 3);
        s_lo = 2'($unsigned($random(seed)) % 3);
        cfg = 8'hFF;
        en = '1;
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd_chk(5'h00, 32'h78);
        rd_chk(5'h01, 32'hFF);
        rd_chk(5'h08, 32'hFF);
        rd_chk(5'h07, 32'h08);
        xf(1'b0, 8'h2C, 32'h0);
        chk("slverr", 32'(err), 32'h1);
        pairs(20'h0);
        @(posedge sys_clk) pg <= 1'b1;
        wait_on;
        chk("bus address", 32'(wa), 32'(exp_addr(s_hi, s_lo)));
        // power-on still has to cross into the reference domain
        repeat (8) @(posedge rclk);
        pairs(mask(en, oe_n, cfg));
        for (int j = 0; j < 8; j++) begin
            en = (j == 0) ? '1 : 20'($random(seed));
            cfg = (j == 0) ? 8'hFF : 8'($random(seed));
            wr(5'h01, 32'(en[7:0]));
            wr(5'h02, 32'(en[15:8]));
            wr(5'h00, 32'({en[19:16], 3'b000}));
            wr(5'h08, 32'(cfg));
            old = mask(en, oe_n, cfg);
            repeat (11) @(posedge rclk);
            pairs(old);
            @(posedge sys_clk) oe_n <= (j == 0) ? 8'h00 : 8'($random(seed));
            repeat (2) @(posedge rclk);
            pairs(old);
            repeat (8) @(posedge rclk);
            pairs(mask(en, oe_n, cfg));
        end
        @(posedge sys_clk) pg <= 1'b0;
        s_hi <= ~s_hi;
        repeat (12) @(posedge rclk);
        pairs(20'h0);
        @(posedge sys_clk) pg <= 1'b1;
        wait_on;
        repeat (8) @(posedge rclk);
        pairs(mask(en, oe_n, cfg));
        chk("bus address", 32'(wa), 32'(exp_addr(~s_hi, s_lo)));
        // mid-run resets, one strap combination each, high strap code 3 included
        for (int k = 0; k < 12; k++) begin
            @(posedge sys_clk) rst_n <= 1'b0;
            pg <= 1'b0;
            s_hi <= 2'(k / 3);
            s_lo <= 2'(k % 3);
            repeat (30) @(posedge sys_clk);
            chk("reset address", 32'(wa), 32'hD8);
            rst_n <= 1'b1;
            repeat (2) @(posedge sys_clk);
            pg <= 1'b1;
            repeat (6) @(posedge sys_clk);
            chk("bus address", 32'(wa), 32'(exp_addr(2'(k / 3), 2'(k % 3))));
        end
        report_and_stop;
    end
endmodule
